/* File: hw/sc_serial.sv */
// smart-card asynchronous serial channel, single clock, config on ports
`timescale 1ns/1ps
// Overview of operation
// - frames run only with serial mode field 101, eight data bits
// - stop-bit control zero gives exactly one stop bit
// - direct convention: even parity, plain data, LSB first
// - inverse convention: odd parity, inverted data, MSB first
// - internal rate is prescaler clock over 16 times reload plus one
// - external rate is channel clock pin over 16 times reload plus one
// - reload value is eight bits, any value 0 to 255
// - no handshake pins; channel runs with handshake disabled
// - no sleep address filtering is offered
// - transmit interrupt fires on completion when selected
// - open-drain option for the shared wire
// - transmit starts only if enabled and buffer loaded
// - receive starts only if enabled and start bit seen
// - receive interrupt when frame lands in receive buffer
// - overrun overwrites buffer, receive interrupt not raised
// - overrun, framing, parity errors plus an error sum flag
// - receiver with signalling on pulls line low on parity error
// - transmitter reads far-end parity error from the line
// - with signalling on, the completion tx interrupt moves to that sample point
// - direct sends data bit zero first, inverse bit seven inverted
// - data inverted at buffer write and read, framing bits not
module sc_serial
    import sc_serial_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire cfg_s       cfg_i,
    input  wire logic       tx_en_i,
    input  wire logic       rx_en_i,
    input  wire logic       tx_wr_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       rx_rd_i,
    input  wire logic       serial_in_pin_i,
    input  wire logic       channel_clock_pin_i,
    output logic            serial_out_pin_o,
    output logic            serial_out_pin_oe_o,
    output logic            tx_empty_o,
    output logic            tx_irq_o,
    output logic            far_perr_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_full_o,
    output logic            rx_irq_o,
    output err_s            err_o
);
    // ********************************
    // pin synchronisers and tick source
    // ********************************
    logic [2:0] rx_sync_ff;
    logic [2:0] ck_sync_ff;
    logic [4:0] pre_ff;
    logic [7:0] brg_ff;    // any reload 0..255 accepted
    logic       run;
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rx_sync_ff <= 3'h7;
            ck_sync_ff <= 3'h0;
        end
        else
        begin
            rx_sync_ff <= {rx_sync_ff[1:0], serial_in_pin_i};
            ck_sync_ff <= {ck_sync_ff[1:0], channel_clock_pin_i};
        end
    end
    wire       line    = rx_sync_ff[1];
    wire       ck_rise = ck_sync_ff[1] & ~ck_sync_ff[2];
    assign run = (cfg_i.mode == SMART_MODE);
    wire [4:0] pre_top = (cfg_i.presc == PRE_BY_ONE) ? DIV_ONE :
                         (cfg_i.presc == PRE_BY_8)   ? DIV_EIGHT : DIV_THIRTY2;
    wire       pre_hit = (pre_ff >= pre_top);
    // rate source: prescaled clock or pin edge
    wire       src     = cfg_i.ext_clk ? ck_rise : pre_hit;
    wire       tick    = src && (brg_ff == 8'h00);
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pre_ff <= 5'h00;
            brg_ff <= 8'h00;
        end
        else
        begin
            pre_ff <= pre_hit ? 5'h00 : pre_ff + 5'h01;
            if (src)
                brg_ff <= (brg_ff == 8'h00) ? cfg_i.reload : brg_ff - 8'h01;
        end
    end
    // ********************************
    // helpers
    // ********************************
    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                            input logic msb);
        shift_in = msb ? {v[6:0], b} : {b, v[7:1]};
    endfunction
    function automatic logic [7:0] conv(input logic [7:0] v, input logic inv);
        conv = inv ? ~v : v;
    endfunction
    // ********************************
    // transmitter
    // ********************************
    tx_e        tx_st_ff;
    logic [3:0] tx_tk_ff;
    logic [3:0] tx_bit_ff;
    logic [7:0] tx_buf_ff;
    logic [7:0] tx_sh_ff;
    logic       tx_par_ff;
    logic       tx_line_ff;
    logic       tx_empty_ff;
    wire        tx_bend = tick && (tx_tk_ff == TICK_LAST);
    wire        tx_go   = run && tx_en_i && !tx_empty_ff && tx_st_ff == TX_IDLE;
    wire        tx_out  = cfg_i.msb_first ? tx_sh_ff[7] : tx_sh_ff[0];
    // parity must also cover the bit leaving in the same cycle
    wire        tx_pbit = tx_par_ff ^ tx_out ^ ~cfg_i.par_even;
    wire        tx_next = cfg_i.msb_first ? tx_sh_ff[6] : tx_sh_ff[1];
    wire        tx_last = (tx_st_ff == TX_STOP) && tx_bend &&
                          (!cfg_i.stop_two || tx_bit_ff[0]);
    wire        tx_echk = (tx_st_ff == TX_ECHK) && tick && tx_tk_ff == TICK_MID;
    // completion point moves to the far-end error sample
    wire        tx_done = cfg_i.err_sig_en ? tx_echk : tx_last;
    wire        tx_irq  = cfg_i.irq_on_done ? tx_done : tx_go;
    tx_e        nxt_tx_st;
    always_comb
    begin
        nxt_tx_st = tx_st_ff;
        unique case (tx_st_ff)
            TX_IDLE: if (tx_go) nxt_tx_st = TX_STRT;
            TX_STRT: if (tx_bend) nxt_tx_st = TX_DATA;
            TX_DATA: if (tx_bend && tx_bit_ff == BIT_LAST)
                         nxt_tx_st = cfg_i.par_en ? TX_PAR : TX_STOP;
            TX_PAR:  if (tx_bend) nxt_tx_st = TX_STOP;
            TX_STOP: if (tx_last) nxt_tx_st = cfg_i.err_sig_en ? TX_ECHK : TX_IDLE;
            TX_ECHK: if (tx_echk) nxt_tx_st = TX_IDLE;
            default: nxt_tx_st = TX_IDLE;
        endcase
        if (!run)
            nxt_tx_st = TX_IDLE;
    end
    // buffer write loses to nothing: a write in the load cycle keeps new data
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            tx_st_ff    <= TX_IDLE;
            tx_tk_ff    <= 4'h0;
            tx_bit_ff   <= 4'h0;
            tx_buf_ff   <= 8'h00;
            tx_sh_ff    <= 8'h00;
            tx_par_ff   <= 1'b0;
            tx_line_ff  <= 1'b1;
            tx_empty_ff <= 1'b1;
            far_perr_o  <= 1'b0;
        end
        else
        begin
            tx_st_ff <= nxt_tx_st;
            if (tx_wr_i)
                tx_buf_ff <= conv(tx_data_i, cfg_i.data_inv);
            tx_empty_ff <= tx_wr_i ? 1'b0 : (tx_go ? 1'b1 : tx_empty_ff);
            tx_tk_ff <= (tx_go || nxt_tx_st != tx_st_ff) ? 4'h0 :
                        (tick ? tx_tk_ff + 4'h1 : tx_tk_ff);
            if (tx_go)
            begin
                tx_sh_ff   <= tx_buf_ff;
                tx_par_ff  <= 1'b0;
                tx_bit_ff  <= 4'h0;
                tx_line_ff <= 1'b0;
            end
            else if (tx_bend)
            begin
                // next bit goes out at the boundary itself, no idle gap after start
                if (tx_st_ff == TX_STRT)
                    tx_line_ff <= tx_out;
                else if (tx_st_ff == TX_DATA)
                begin
                    tx_par_ff <= tx_par_ff ^ tx_out;
                    tx_sh_ff  <= cfg_i.msb_first ? {tx_sh_ff[6:0], 1'b0}
                                                 : {1'b0, tx_sh_ff[7:1]};
                    tx_bit_ff <= tx_bit_ff + 4'h1;
                    tx_line_ff <= (tx_bit_ff == BIT_LAST) ?
                                  (cfg_i.par_en ? tx_pbit : 1'b1) : tx_next;
                end
                else if (tx_st_ff == TX_STOP)
                begin
                    tx_bit_ff  <= tx_bit_ff + 4'h1;
                    tx_line_ff <= 1'b1;
                end
                else
                    tx_line_ff <= 1'b1;
                if (tx_st_ff == TX_PAR || tx_st_ff == TX_STRT)
                    tx_bit_ff <= 4'h0;
            end
            // line low at the sample point means the card flagged parity
            if (tx_echk)
                far_perr_o <= ~line;
        end
    end
    // ********************************
    // receiver
    // ********************************
    rx_e        rx_st_ff;
    logic [3:0] rx_tk_ff;
    logic [3:0] rx_bit_ff;
    logic [7:0] rx_sh_ff;
    logic       rx_par_ff;
    logic [4:0] err_cnt_ff;
    wire        rx_smp = tick && rx_tk_ff == TICK_MID;
    wire        rx_go  = run && rx_en_i && rx_st_ff == RX_IDLE && !line;
    wire        rx_end = (rx_st_ff == RX_STOP) && rx_smp;
    wire        par_bad = cfg_i.par_en && (rx_par_ff ^ ~cfg_i.par_even);
    wire        ovr    = rx_end && rx_full_o;
    rx_e        nxt_rx_st;
    always_comb
    begin
        nxt_rx_st = rx_st_ff;
        unique case (rx_st_ff)
            RX_IDLE: if (rx_go) nxt_rx_st = RX_STRT;
            // false start if line back high at mid start bit
            RX_STRT: if (rx_smp) nxt_rx_st = line ? RX_IDLE : RX_DATA;
            RX_DATA: if (rx_smp && rx_bit_ff == BIT_LAST)
                         nxt_rx_st = cfg_i.par_en ? RX_PAR : RX_STOP;
            RX_PAR:  if (rx_smp) nxt_rx_st = RX_STOP;
            RX_STOP: if (rx_smp) nxt_rx_st = RX_IDLE;
            default: nxt_rx_st = RX_IDLE;
        endcase
        if (!run)
            nxt_rx_st = RX_IDLE;
    end
    // bit timer restarts at each sample so later bits stay mid-aligned
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rx_st_ff  <= RX_IDLE;
            rx_tk_ff  <= 4'h0;
            rx_bit_ff <= 4'h0;
            rx_sh_ff  <= 8'h00;
            rx_par_ff <= 1'b0;
        end
        else
        begin
            rx_st_ff <= nxt_rx_st;
            if (rx_go)
                rx_tk_ff <= 4'h0;
            else if (tick)
                rx_tk_ff <= (rx_smp && rx_st_ff != RX_STRT) ? 4'h8 : rx_tk_ff + 4'h1;
            if (rx_smp && rx_st_ff == RX_STRT)
            begin
                rx_bit_ff <= 4'h0;
                rx_par_ff <= 1'b0;
            end
            if (rx_smp && rx_st_ff == RX_DATA)
            begin
                rx_sh_ff  <= shift_in(rx_sh_ff, line, cfg_i.msb_first);
                rx_par_ff <= rx_par_ff ^ line;
                rx_bit_ff <= rx_bit_ff + 4'h1;
            end
            if (rx_smp && rx_st_ff == RX_PAR)
                rx_par_ff <= rx_par_ff ^ line;
        end
    end
    // buffer, flags; a set in the read cycle wins over the clear
    wire err_fr = rx_end && !line;
    wire err_pa = rx_end && par_bad;
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rx_data_o  <= 8'h00;
            rx_full_o  <= 1'b0;
            rx_irq_o   <= 1'b0;
            err_o      <= '0;
            err_cnt_ff <= 5'h00;
        end
        else
        begin
            if (rx_end)
                rx_data_o <= conv(rx_sh_ff, cfg_i.data_inv);
            rx_full_o <= rx_end | (rx_full_o & ~rx_rd_i);
            rx_irq_o  <= rx_end && !ovr;
            err_o.overrun <= ovr    | (err_o.overrun & ~rx_rd_i);
            err_o.framing <= err_fr | (err_o.framing & ~rx_rd_i);
            err_o.parity  <= err_pa | (err_o.parity & ~rx_rd_i);
            err_o.sum     <= ovr | err_fr | err_pa |
                             ((err_o.overrun | err_o.framing | err_o.parity) & ~rx_rd_i);
            if (err_pa && cfg_i.err_sig_en)
                err_cnt_ff <= ERR_TICKS;
            else if (tick && err_cnt_ff != 5'h00)
                err_cnt_ff <= err_cnt_ff - 5'h01;
        end
    end
    // ********************************
    // pin driver
    // ********************************
    wire lvl = tx_line_ff && (err_cnt_ff == 5'h00);
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            serial_out_pin_o    <= 1'b1;
            serial_out_pin_oe_o <= 1'b1;
            tx_empty_o          <= 1'b1;
            tx_irq_o            <= 1'b0;
        end
        else
        begin
            // open drain only pulls low, pull-up makes the high
            serial_out_pin_o    <= cfg_i.open_drain ? 1'b0 : lvl;
            serial_out_pin_oe_o <= cfg_i.open_drain ? ~lvl : 1'b1;
            tx_empty_o          <= tx_wr_i ? 1'b0 : (tx_go ? 1'b1 : tx_empty_ff);
            tx_irq_o            <= tx_irq;
        end
    end
    // handshake and sleep filtering are deliberately absent
    // ********************************
    // assertions
    // ********************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_perr_seen;
        err_pa && cfg_i.err_sig_en;
    endsequence
    sequence s_line_low;
        serial_out_pin_oe_o && !serial_out_pin_o;
    endsequence
    AST_TX_START: assert property (tx_st_ff == TX_IDLE && nxt_tx_st == TX_STRT
        |-> tx_en_i && !tx_empty_ff) else $error("tx started without data");
    AST_RX_START: assert property ($rose(rx_st_ff == RX_STRT)
        |-> $past(rx_en_i) && !$past(line)) else $error("rx started wrongly");
    AST_MODE: assert property (!run |=> tx_st_ff == TX_IDLE && rx_st_ff == RX_IDLE)
        else $error("fsm active outside smart mode");
    AST_OVR: assert property (ovr |=> !rx_irq_o && err_o.overrun)
        else $error("overrun raised irq");
    AST_RX_IRQ: assert property (rx_end && !rx_full_o |=> rx_irq_o && rx_full_o)
        else $error("rx irq missing");
    AST_ERR_SIG: assert property (s_perr_seen |=> !lvl ##1 s_line_low [*8])
        else $error("parity error not driven low");
    AST_SUM: assert property (err_o.sum == (err_o.overrun | err_o.framing | err_o.parity))
        else $error("error sum mismatch");
    AST_DONE_IRQ: assert property (cfg_i.err_sig_en && cfg_i.irq_on_done && tx_irq
        |-> tx_st_ff == TX_ECHK) else $error("tx irq outside sample point");
    AST_OD: assert property (cfg_i.open_drain |=> !serial_out_pin_o)
        else $error("open drain drove high");
    AST_TICK: assert property (tick && cfg_i.reload != 8'h00 && !cfg_i.ext_clk
        |=> !tick) else $error("bit rate tick too fast");
endmodule

/* File: shared/sc_serial_pkg.sv */
// constants and carrier types for the smart-card serial channel
package sc_serial_pkg;
    // ********************************
    // frame and timing
    // ********************************
    localparam logic [2:0] SMART_MODE  = 3'h5;  // 8-bit asynchronous frame
    localparam int         DATA_BITS   = 8;
    localparam logic [3:0] TICK_LAST   = 4'hF;  // 16 ticks per bit
    localparam logic [3:0] TICK_MID    = 4'h7;  // sample point inside a bit
    localparam logic [3:0] BIT_LAST    = 4'h7;  // index of last data bit
    localparam logic [4:0] ERR_TICKS   = 5'h18; // error low lasts 1.5 bits
    // ********************************
    // prescaler select codes and ratios
    // ********************************
    localparam logic [1:0] PRE_BY_ONE  = 2'h0;
    localparam logic [1:0] PRE_BY_8    = 2'h1;
    localparam logic [4:0] DIV_ONE     = 5'h00; // terminal counts
    localparam logic [4:0] DIV_EIGHT   = 5'h07;
    localparam logic [4:0] DIV_THIRTY2 = 5'h1F;

    typedef struct packed {
        logic [2:0] mode;        // serial mode field
        logic       ext_clk;     // 1: channel clock pin drives rate
        logic       stop_two;    // 0: one stop bit
        logic       par_even;    // 1: even parity
        logic       par_en;      // parity bit present
        logic       hs_disable;  // handshake off
        logic       msb_first;
        logic       data_inv;    // data logic inverse
        logic       irq_on_done; // tx interrupt at completion
        logic       open_drain;
        logic       err_sig_en;  // parity error signalling
        logic [1:0] presc;       // prescaler select
        logic [7:0] reload;      // bit rate reload n
    } cfg_s;

    typedef struct packed {
        logic overrun;
        logic framing;
        logic parity;
        logic sum;
    } err_s;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_STRT = 3'b001,
        TX_DATA = 3'b010,
        TX_PAR  = 3'b011,
        TX_STOP = 3'b100,
        TX_ECHK = 3'b101
    } tx_e;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_STRT = 3'b001,
        RX_DATA = 3'b010,
        RX_PAR  = 3'b011,
        RX_STOP = 3'b100
    } rx_e;
endpackage

/* File: test/sc_card_model.sv */
// card model hanging on the pulled-up shared line
`timescale 1ns/1ps
module sc_card_model
(
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      pull_low_o
);
    initial pull_low_o = 1'b0;

    // ********************************
    // card side tasks
    // ********************************
    // bit 0 of seq goes first, 16 clocks a bit; a released line floats to the pull-up
    task automatic send(input logic [10:0] seq);
        for (int i = 0; i < 11; i++)
        begin
            @(posedge clk_i);
            pull_low_o <= ~seq[i];
            repeat (15) @(posedge clk_i);
        end
        @(posedge clk_i);
        pull_low_o <= 1'b0;
    endtask

    // mid-bit sampling; with nak set the card holds the line low 24 clocks after any frame, good or bad
    task automatic receive(input logic nak, output logic [10:0] seq);
        int n;
        n = 0;
        while (line_i !== 1'b0 && n < 400)
        begin
            @(negedge clk_i);
            n++;
        end
        repeat (8) @(negedge clk_i);
        for (int i = 0; i < 11; i++)
        begin
            seq[i] = line_i;
            if (i < 10)
                repeat (16) @(negedge clk_i);
        end
        repeat (8) @(posedge clk_i);
        pull_low_o <= nak;
        repeat (24) @(posedge clk_i);
        pull_low_o <= 1'b0;
    endtask
endmodule

/* File: test/testbench.sv */
// self-checking bench for the smart-card serial channel
`timescale 1ns/1ps
module testbench
    import sc_serial_pkg::*;
;
    logic       clk_i     = 1'b0;
    logic       sys_rst_i = 1'b1;
    cfg_s       cfg_i     = '0;
    logic       tx_en_i   = 1'b0;
    logic       rx_en_i   = 1'b0;
    logic       tx_wr_i   = 1'b0;
    logic       rx_rd_i   = 1'b0;
    logic       ext_pin   = 1'b0;
    logic [7:0] tx_data_i = 8'h00;
    logic       out, oe, tx_empty_o, tx_irq_o, far_perr_o, rx_full_o, rx_irq_o, card_low, line;
    logic [7:0] rx_data_o;
    err_s       err_o;
    int         errors, num_checks, cycles;

    // ********************************
    // clock, shared wire, hang guard
    // ********************************
    always #50 clk_i = ~clk_i;
    assign line = (oe ? out : 1'b1) & ~card_low; // pull-up wins when nobody pulls low

    // external rate pin toggles every two clocks; the run is cut short if it hangs
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles[0])
            ext_pin <= ~ext_pin;
        if (cycles == 90000)
        begin
            errors++;
            give_verdict();
        end
    end

    sc_serial uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_i(cfg_i), .tx_en_i(tx_en_i),
        .rx_en_i(rx_en_i), .tx_wr_i(tx_wr_i), .tx_data_i(tx_data_i), .rx_rd_i(rx_rd_i),
        .serial_in_pin_i(line), .channel_clock_pin_i(ext_pin), .serial_out_pin_o(out),
        .serial_out_pin_oe_o(oe), .tx_empty_o(tx_empty_o), .tx_irq_o(tx_irq_o),
        .far_perr_o(far_perr_o), .rx_data_o(rx_data_o), .rx_full_o(rx_full_o),
        .rx_irq_o(rx_irq_o), .err_o(err_o));
    sc_card_model card (.clk_i(clk_i), .line_i(line), .pull_low_o(card_low));

    // ********************************
    // shared tasks
    // ********************************
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic set_cfg(input logic inv, sig, od, ext, input logic [1:0] pre,
                           input logic [7:0] n);
        @(posedge clk_i);
        cfg_i <= '{mode: SMART_MODE, ext_clk: ext, stop_two: 1'b0, par_even: ~inv,
                   par_en: 1'b1, hs_disable: 1'b1, msb_first: inv, data_inv: inv,
                   irq_on_done: 1'b1, open_drain: od, err_sig_en: sig, presc: pre, reload: n};
    endtask

    // wire image: start, data as sent, parity, stop; inverse sends inverted MSB first
    function automatic logic [10:0] frame(input logic [7:0] d, input logic inv, bad);
        logic [7:0] w;
        for (int i = 0; i < 8; i++)
            w[i] = inv ? ~d[7 - i] : d[i];
        return {1'b1, (inv ? ~^w : ^w) ^ bad, w, 1'b0};
    endfunction

    task automatic put(input logic [7:0] d);
        @(posedge clk_i);
        tx_wr_i   <= 1'b1;
        tx_data_i <= d;
        @(posedge clk_i);
        tx_wr_i   <= 1'b0;
    endtask

    task automatic wait_irq(output int n);
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end
        while (tx_irq_o !== 1'b1 && n < 50000);
    endtask

    // ********************************
    // scenarios
    // ********************************
    // data written while disabled or in a foreign mode must wait in the buffer
    task automatic tx_gate();
        logic [10:0] seq;
        int          n;
        set_cfg(1'b0, 1'b0, 1'b0, 1'b0, PRE_BY_ONE, 8'h00);
        put(8'hC3);
        repeat (40) @(negedge clk_i);
        check("held while disabled", 16'h0001, 16'({tx_empty_o, line}));
        @(posedge clk_i);
        tx_en_i    <= 1'b1;
        cfg_i.mode <= 3'h0;
        repeat (40) @(negedge clk_i);
        check("held in other mode", 16'h0001, 16'({tx_empty_o, line}));
        @(posedge clk_i);
        cfg_i.mode <= SMART_MODE;
        fork
            card.receive(1'b0, seq);
            wait_irq(n);
        join
        check("released frame", 16'(frame(8'hC3, 1'b0, 1'b0)), 16'(seq));
        $display("test tx_gate done");
    endtask

    task automatic tx_test(input logic [7:0] d, input logic inv, sig, od, nak);
        logic [10:0] seq;
        int          n;
        set_cfg(inv, sig, od, 1'b0, PRE_BY_ONE, 8'h00);
        tx_en_i <= 1'b1;
        fork
            put(d);
            card.receive(nak, seq);
            wait_irq(n);
        join
        check("tx frame", 16'(frame(d, inv, 1'b0)), 16'(seq));
        check("tx irq at end", 16'h0001, 16'(n > (sig ? 186 : 177) && n < (sig ? 196 : 187)));
        check("tx buffer empty", 16'h0001, 16'(tx_empty_o));
        if (sig)
            check("far parity error", 16'(nak), 16'(far_perr_o));
        $display("test tx %h done", d);
    endtask

    task automatic rx_test(input logic [7:0] d, input logic inv, sig, bad, stop, en,
                           input logic [3:0] ef, input int irq_exp, input logic rd);
        logic [10:0] seq;
        int          irqs;
        int          lows;
        irqs = 0;
        lows = 0;
        seq = frame(d, inv, bad);
        seq[10] = stop;
        set_cfg(inv, sig, 1'b0, 1'b0, PRE_BY_ONE, 8'h00);
        rx_en_i <= en;
        fork
            card.send(seq);
            repeat (230)
            begin
                @(negedge clk_i);
                irqs += int'(rx_irq_o);
                lows += int'(oe && !out);
            end
        join
        check("rx irq count", 16'(irq_exp), 16'(irqs));
        check("rx flags", 16'(ef), 16'(err_o));
        check("error signal", (sig && bad) ? 16'd24 : 16'd0, 16'(lows));
        if (en)
            check("rx data", 16'(d), 16'(rx_data_o));
        @(posedge clk_i);
        rx_en_i <= 1'b0;
        repeat (250) @(posedge clk_i);
        if (rd)
        begin
            rx_rd_i <= 1'b1;
            @(posedge clk_i);
            rx_rd_i <= 1'b0;
            @(negedge clk_i);
            check("flags cleared", 16'h0000, 16'({rx_full_o, err_o}));
        end
        $display("test rx %h done", d);
    endtask

    // times one data bit of 0x01 on the wire
    task automatic rate_test(input logic ext, input logic [1:0] pre, input logic [7:0] n,
                             input int exp);
        int len;
        int k;
        len = 0;
        k = 0;
        set_cfg(1'b0, 1'b0, 1'b0, ext, pre, n);
        tx_en_i <= 1'b1;
        put(8'h01);
        while (line !== 1'b0 && k < 20000)
        begin
            @(negedge clk_i);
            k++;
        end
        while (line !== 1'b1 && k < 20000)
        begin
            @(negedge clk_i);
            k++;
        end
        while (line === 1'b1 && k < 20000)
        begin
            @(negedge clk_i);
            k++;
            len++;
        end
        check("bit length", 16'(exp), 16'(len));
        wait_irq(k);
        $display("test rate %0d done", exp);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial
    begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        tx_gate();
        tx_test(8'hA5, 1'b0, 1'b0, 1'b0, 1'b0);
        tx_test(8'h3B, 1'b1, 1'b0, 1'b1, 1'b0);
        tx_test(8'h5C, 1'b0, 1'b1, 1'b0, 1'b1);
        tx_test(8'h5C, 1'b0, 1'b1, 1'b0, 1'b0);
        rx_test(8'h96, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 1, 1'b1);
        rx_test(8'h3B, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 1, 1'b1);
        rx_test(8'h11, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 0, 1'b0);
        rx_test(8'h21, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 1, 1'b0);
        rx_test(8'h42, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 4'h9, 0, 1'b1);
        rx_test(8'h7E, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h5, 1, 1'b1);
        rx_test(8'h81, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 4'h3, 1, 1'b1);
        rx_test(8'hE7, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'h3, 1, 1'b1);
        rate_test(1'b1, PRE_BY_ONE, 8'h02, 192);
        rate_test(1'b0, PRE_BY_8, 8'h01, 256);
        rate_test(1'b0, 2'h2, 8'h00, 512);
        rate_test(1'b0, PRE_BY_ONE, 8'hFF, 4096);
        give_verdict();
    end
endmodule
